// ===== fbfc_pkg.sv
// Package: register map, field layout, reset values and types of the FIFO and framing block
package fbfc_pkg;

  // ****************************************************************
  // Register offsets on the host register port
  // ****************************************************************
  localparam logic [5:0] FBFC_ADDR_DATA_PORT = 6'h09;  // fifo_data_port
  localparam logic [5:0] FBFC_ADDR_OCCUPANCY = 6'h0a;  // fifo_occupancy
  localparam logic [5:0] FBFC_ADDR_THRESHOLD = 6'h0b;  // fifo_warning_threshold
  localparam logic [5:0] FBFC_ADDR_MISC_CTRL = 6'h0c;  // misc_control
  localparam logic [5:0] FBFC_ADDR_BIT_FRAME = 6'h0d;  // bit_framing_control

  // ****************************************************************
  // Buffer geometry
  // ****************************************************************
  localparam int         FBFC_DEPTH      = 64;         // Bytes held
  localparam logic [6:0] FBFC_DEPTH_CNT  = 7'h40;      // Depth as a count value
  localparam logic [6:0] FBFC_CNT_ONE    = 7'h01;      // One stored byte
  localparam logic [1:0] FBFC_SKID_FULL  = 2'h2;       // Skid buffer entries

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FBFC_FLUSH_BIT      = 7;              // purge_pointers_bit
  localparam int FBFC_HALT_BIT       = 7;              // timer_halt_strobe
  localparam int FBFC_LAUNCH_BIT     = 6;              // timer_launch_strobe
  localparam int FBFC_SEND_BIT       = 7;              // send_trigger_bit
  localparam int FBFC_ALIGN_LSB      = 4;              // rx_first_bit_position low bit
  localparam int FBFC_ALIGN_MSB      = 6;              // rx_first_bit_position high bit
  localparam int FBFC_TXBITS_MSB     = 2;              // tx_final_byte_bit_count high bit
  localparam int FBFC_THRESH_MSB     = 5;              // warning_threshold high bit

  // ****************************************************************
  // Reset values and constant read-back patterns
  // ****************************************************************
  localparam logic [5:0] FBFC_THRESH_RST   = 6'h08;    // Warning threshold at reset
  localparam logic [7:0] FBFC_MISC_RSVD_RD = 8'h10;    // Reserved misc bits read back
  localparam logic [2:0] FBFC_POS_LAST     = 3'h7;     // Highest bit slot in a byte

  // ****************************************************************
  // Modem state codes shown to the host
  // ****************************************************************
  localparam logic [2:0] FBFC_MODEM_IDLE = 3'h0;       // Idle
  localparam logic [2:0] FBFC_MODEM_WAIT = 3'h1;       // Waiting for send trigger
  localparam logic [2:0] FBFC_MODEM_SEND = 3'h3;       // Transmitting

  // Send sequencer states, one-hot
  typedef enum logic [2:0] {
    FBFC_ST_IDLE = 3'b001,
    FBFC_ST_WAIT = 3'b010,
    FBFC_ST_SEND = 3'b100
  } fbfc_state_e;

  // Byte handed to the serial transmitter
  typedef struct packed {
    logic [7:0] data;                                  // Byte value
    logic       last;                                  // Final byte of the frame
    logic [2:0] nbits;                                 // Bits to send, 0 means all eight
  } fbfc_tx_word_s;

  // Bit delivered by the serial receiver
  typedef struct packed {
    logic bit_value;                                   // Received bit
    logic frame_end;                                   // Frame closes, no bit carried
  } fbfc_rx_bit_s;

endpackage : fbfc_pkg

// ===== fbfc_fifo_framing.sv
// Module: 64-byte host FIFO with warning flags, timer strobes and bit framing control
//
// Behaviour
// [R1] One byte port reaches a 64-byte buffer
// [R2] Serial datapath moves whole bytes through buffer
// [R3] Flush empties pointers and clears overflow flag
// [R4] Flush bit always reads back zero
// [R5] Seven-bit count follows host writes and reads
// [R6] Six-bit threshold, read-write, resets to eight
// [R7] Near-full when free space within threshold
// [R8] Near-empty when count within threshold
// [R9] Timer stop and start strobes; start reads zero
// [R10] Final received byte valid bits, zero means eight
// [R11] Send trigger acts only during send-then-receive
// [R12] Alignment picks slot of first received bit
// [R13] Alignment seven wraps second bit to next byte
// [R14] Host uses nonzero alignment only for anticollision
// [R15] Transmit final byte bit count, zero means all
// [R16] Modem state shows waiting-for-trigger code
// [R17] Write when full is dropped, sets overflow
// [R18] Read when empty leaves count at zero
`timescale 1ns/1ps

module fbfc_fifo_framing
  import fbfc_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          resetn,
  // Host register port
  input  wire logic [5:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [7:0]    reg_wdata,
  output logic      [7:0]    reg_rdata,
  // Status toward the wider device
  output logic               near_full_flag,
  output logic               near_empty_flag,
  output logic               overflow_error_flag,
  output logic      [2:0]    modem_state_indicator,
  // Timer strobes
  output logic               timer_halt_strobe,
  output logic               timer_launch_strobe,
  // Command state from the command sequencer
  input  wire logic          transceive_active,
  // Transmit byte stream
  output logic               tx_valid,
  input  wire logic          tx_ready,
  output fbfc_tx_word_s      tx_word,
  // Receive bit stream
  input  wire logic          rx_valid,
  output logic               rx_ready,
  input  wire fbfc_rx_bit_s  rx_bit
);

  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [7:0]    mem [FBFC_DEPTH];                     // Buffer bytes
  logic [5:0]    wr_ptr_reg;                           // Write pointer
  logic [5:0]    rd_ptr_reg;                           // Read pointer
  logic [6:0]    count_reg;                            // occupancy_count
  logic [5:0]    thresh_reg;                           // warning_threshold
  logic          ovfl_reg;                             // Overflow flag
  logic [2:0]    align_reg;                            // rx_first_bit_position
  logic [2:0]    txbits_reg;                           // tx_final_byte_bit_count
  logic [2:0]    rxlast_reg;                           // rx_final_byte_valid_count
  fbfc_state_e   state_reg;                            // Send sequencer
  fbfc_state_e   state_next;                           // Next sequencer state
  logic          halt_reg;                             // Timer stop pulse
  logic          launch_reg;                           // Timer start pulse
  logic [7:0]    rdata_reg;                            // Read data flop
  // Receive assembler
  logic [7:0]    asm_reg;                              // Byte under assembly
  logic [2:0]    pos_reg;                              // Next bit slot
  logic          active_reg;                           // Frame in progress
  logic          part_reg;                             // Current byte holds bits
  logic [7:0]    pend_reg;                             // Completed byte awaiting push
  logic          pend_valid_reg;                       // Pending byte present
  // Two-entry skid buffer on the transmit side
  fbfc_tx_word_s skid [2];                             // Entries
  logic          skid_wp_reg;                          // Skid write index
  logic          skid_rp_reg;                          // Skid read index
  logic [1:0]    skid_cnt_reg;                         // Skid occupancy

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire sel_data   = (reg_addr == FBFC_ADDR_DATA_PORT);
  wire sel_occ    = (reg_addr == FBFC_ADDR_OCCUPANCY);
  wire sel_thr    = (reg_addr == FBFC_ADDR_THRESHOLD);
  wire sel_misc   = (reg_addr == FBFC_ADDR_MISC_CTRL);
  wire sel_frame  = (reg_addr == FBFC_ADDR_BIT_FRAME);
  wire fifo_empty = (count_reg == 7'h00);
  wire fifo_full  = (count_reg == FBFC_DEPTH_CNT);
  wire flush      = reg_wr && sel_occ && reg_wdata[FBFC_FLUSH_BIT];  // [R3]
  wire host_wr    = reg_wr && sel_data;                               // [R1]
  wire host_rd    = reg_rd && sel_data;                               // [R1]
  // A full write is dropped and flags overflow
  wire host_push  = host_wr && !fifo_full;                            // [R17]
  wire host_ovfl  = host_wr && fifo_full;                             // [R17]
  // Empty read leaves pointers alone
  wire host_pop   = host_rd && !fifo_empty;                           // [R18]
  // Host port has priority; the serial side waits a cycle
  wire rx_push    = pend_valid_reg && !host_wr && !fifo_full && !flush;        // [R2]
  wire tx_pop     = (state_reg == FBFC_ST_SEND) && !fifo_empty && !host_rd
                    && !flush && (skid_cnt_reg != FBFC_SKID_FULL);             // [R2]
  wire push       = host_push || rx_push;
  wire pop        = host_pop || tx_pop;
  wire send_hit   = reg_wr && sel_frame && reg_wdata[FBFC_SEND_BIT];

  // ****************************************************************
  // Warning flags
  // ****************************************************************
  wire [6:0] free_space = FBFC_DEPTH_CNT - count_reg;
  assign near_full_flag  = (free_space <= {1'b0, thresh_reg});   // [R7]
  assign near_empty_flag = (count_reg <= {1'b0, thresh_reg});    // [R8]
  assign overflow_error_flag = ovfl_reg;

  // ****************************************************************
  // Read-back mux
  // ****************************************************************
  // Write-only bits (flush, timer strobes, send trigger) read as zero
  wire [7:0] rd_occ   = {1'b0, count_reg};                                  // [R4] [R5]
  wire [7:0] rd_thr   = {2'b00, thresh_reg};                                // [R6]
  wire [7:0] rd_misc  = FBFC_MISC_RSVD_RD | {5'h00, rxlast_reg};            // [R9] [R10]
  wire [7:0] rd_frame = {1'b0, align_reg, 1'b0, txbits_reg};                // [R12] [R15]
  // Empty read returns zero as its undefined byte
  wire [7:0] rd_data  = fifo_empty ? 8'h00 : mem[rd_ptr_reg];               // [R18]
  wire [7:0] rd_mux   = sel_data  ? rd_data  :
                        sel_occ   ? rd_occ   :
                        sel_thr   ? rd_thr   :
                        sel_misc  ? rd_misc  :
                        sel_frame ? rd_frame : 8'h00;
  assign reg_rdata = rdata_reg;

  // Capture read data on the read strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  // ****************************************************************
  // Buffer pointers and count
  // ****************************************************************
  // Byte memory has no reset; contents are don't-care until written
  always_ff @(posedge clock) if (push) mem[wr_ptr_reg] <= host_push ? reg_wdata : pend_reg;  // [R1] [R2]

  // Pointers wrap naturally at 64; flush wins over any traffic
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= 6'h00;
      rd_ptr_reg <= 6'h00;
      count_reg  <= 7'h00;
    end else if (flush) begin
      wr_ptr_reg <= 6'h00;                                      // [R3]
      rd_ptr_reg <= 6'h00;                                      // [R3]
      count_reg  <= 7'h00;                                      // [R3]
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 6'h01;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 6'h01;
      // Count follows pushes and pops
      if (push && !pop) begin
        count_reg <= count_reg + FBFC_CNT_ONE;                  // [R5]
      end else if (pop && !push) begin
        count_reg <= count_reg - FBFC_CNT_ONE;                  // [R5]
      end
    end
  end

  // Overflow flag: a new overflow beats a flush in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ovfl_reg <= 1'b0;
    end else if (host_ovfl) begin
      ovfl_reg <= 1'b1;                                         // [R17]
    end else if (flush) begin
      ovfl_reg <= 1'b0;                                         // [R3]
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      thresh_reg <= FBFC_THRESH_RST;                            // [R6]
      align_reg  <= 3'h0;
      txbits_reg <= 3'h0;
    end else begin
      if (reg_wr && sel_thr) begin
        thresh_reg <= reg_wdata[FBFC_THRESH_MSB:0];             // [R6]
      end
      if (reg_wr && sel_frame) begin
        align_reg  <= reg_wdata[FBFC_ALIGN_MSB:FBFC_ALIGN_LSB]; // [R12] [R14]
        txbits_reg <= reg_wdata[FBFC_TXBITS_MSB:0];             // [R15]
      end
    end
  end

  // Timer strobes last one cycle per write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      halt_reg   <= 1'b0;
      launch_reg <= 1'b0;
    end else begin
      halt_reg   <= reg_wr && sel_misc && reg_wdata[FBFC_HALT_BIT];    // [R9]
      launch_reg <= reg_wr && sel_misc && reg_wdata[FBFC_LAUNCH_BIT];  // [R9]
    end
  end
  assign timer_halt_strobe   = halt_reg;
  assign timer_launch_strobe = launch_reg;

  // ****************************************************************
  // Send sequencer
  // ****************************************************************
  // Trigger only counts while send-then-receive runs
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FBFC_ST_IDLE: if (transceive_active) state_next = FBFC_ST_WAIT;
      FBFC_ST_WAIT: if (!transceive_active) state_next = FBFC_ST_IDLE;
                    else if (send_hit) state_next = FBFC_ST_SEND;  // [R11]
      FBFC_ST_SEND: begin
        // Ends on the last byte leaving, an empty buffer or command abort
        if (!transceive_active || (tx_pop && count_reg == FBFC_CNT_ONE) || fifo_empty) begin
          state_next = FBFC_ST_IDLE;
        end
      end
      default: state_next = FBFC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= FBFC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Modem code seen by the host
  assign modem_state_indicator = (state_reg == FBFC_ST_WAIT) ? FBFC_MODEM_WAIT :  // [R16]
                                 (state_reg == FBFC_ST_SEND) ? FBFC_MODEM_SEND :
                                 FBFC_MODEM_IDLE;

  // ****************************************************************
  // Transmit skid buffer
  // ****************************************************************
  // Final byte carries the partial bit count
  wire            tx_last  = (count_reg == FBFC_CNT_ONE);
  fbfc_tx_word_s  tx_entry;
  assign tx_entry = '{data: mem[rd_ptr_reg], last: tx_last,
                      nbits: tx_last ? txbits_reg : 3'h0};      // [R15]
  wire            tx_take  = tx_valid && tx_ready;

  // Stalls by the transmitter fill this, then hold the buffer pop
  always_ff @(posedge clock) if (tx_pop) skid[skid_wp_reg] <= tx_entry;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      skid_wp_reg  <= 1'b0;
      skid_rp_reg  <= 1'b0;
      skid_cnt_reg <= 2'h0;
    end else if (flush) begin
      skid_wp_reg  <= 1'b0;
      skid_rp_reg  <= 1'b0;
      skid_cnt_reg <= 2'h0;
    end else begin
      if (tx_pop) skid_wp_reg <= ~skid_wp_reg;
      if (tx_take) skid_rp_reg <= ~skid_rp_reg;
      if (tx_pop && !tx_take) begin
        skid_cnt_reg <= skid_cnt_reg + 2'h1;
      end else if (tx_take && !tx_pop) begin
        skid_cnt_reg <= skid_cnt_reg - 2'h1;
      end
    end
  end
  assign tx_valid = (skid_cnt_reg != 2'h0);
  assign tx_word  = skid[skid_rp_reg];

  // ****************************************************************
  // Receive bit assembler
  // ****************************************************************
  // One pending byte; new bits wait until it enters the buffer
  assign rx_ready = !pend_valid_reg;
  wire   rx_take  = rx_valid && rx_ready;
  wire   rx_bit_in = rx_take && !rx_bit.frame_end;
  wire   rx_end_in = rx_take && rx_bit.frame_end;
  wire [2:0] slot  = active_reg ? pos_reg : align_reg;         // [R12]
  logic  [7:0] asm_next;
  always_comb begin
    asm_next       = active_reg ? asm_reg : 8'h00;
    asm_next[slot] = rx_bit.bit_value;                          // [R12]
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      asm_reg        <= 8'h00;
      pos_reg        <= 3'h0;
      active_reg     <= 1'b0;
      part_reg       <= 1'b0;
      pend_reg       <= 8'h00;
      pend_valid_reg <= 1'b0;
      rxlast_reg     <= 3'h0;
    end else begin
      if (rx_push || flush) begin
        pend_valid_reg <= 1'b0;
      end
      if (rx_bit_in) begin
        active_reg <= 1'b1;
        pos_reg    <= slot + 3'h1;                              // [R13]
        if (slot == FBFC_POS_LAST) begin
          // Byte complete; next bit lands in slot 0 of a new byte
          pend_reg       <= asm_next;                           // [R13]
          pend_valid_reg <= 1'b1;
          asm_reg        <= 8'h00;
          part_reg       <= 1'b0;
        end else begin
          asm_reg  <= asm_next;
          part_reg <= 1'b1;
        end
      end else if (rx_end_in) begin
        active_reg <= 1'b0;
        rxlast_reg <= part_reg ? pos_reg : 3'h0;                // [R10]
        if (part_reg) begin
          pend_reg       <= asm_reg;                            // [R2]
          pend_valid_reg <= 1'b1;
        end
        part_reg <= 1'b0;
        asm_reg  <= 8'h00;
      end
    end
  end

endmodule : fbfc_fifo_framing

// ===== fbfc_fifo_framing_asserts.sv
// Checker: port-level assertions for the FIFO and framing block
`timescale 1ns/1ps
module fbfc_fifo_framing_chk
  import fbfc_pkg::*;
(
  // Clock and reset
  input wire logic          clock,
  input wire logic          resetn,
  // Host register port
  input wire logic [5:0]    reg_addr,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [7:0]    reg_wdata,
  input wire logic [7:0]    reg_rdata,
  // Status and strobes
  input wire logic          near_full_flag,
  input wire logic          near_empty_flag,
  input wire logic          overflow_error_flag,
  input wire logic [2:0]    modem_state_indicator,
  input wire logic          timer_halt_strobe,
  input wire logic          timer_launch_strobe,
  // Serial streams
  input wire logic          transceive_active,
  input wire logic          tx_valid,
  input wire logic          tx_ready,
  input wire fbfc_tx_word_s tx_word,
  input wire logic          rx_valid,
  input wire logic          rx_ready,
  input wire fbfc_rx_bit_s  rx_bit
);
  // ****************************************
  // Decoded host writes
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire wr_misc   = reg_wr && reg_addr == FBFC_ADDR_MISC_CTRL;  // Control write
  wire wr_frame  = reg_wr && reg_addr == FBFC_ADDR_BIT_FRAME;  // Framing write
  wire flush     = reg_wr && reg_addr == FBFC_ADDR_OCCUPANCY && reg_wdata[7];
  wire launch_wr = wr_misc && reg_wdata[6];                    // Start request
  wire [2:0] ms  = modem_state_indicator;                      // Short alias
  // ****************************************
  // Assertions
  // ****************************************
  a_halt_strobe: assert property (wr_misc && reg_wdata[7] |=> timer_halt_strobe)
    else $error("halt strobe missing");
  a_launch_cause: assert property (timer_launch_strobe |-> $past(launch_wr))
    else $error("launch strobe without a start write");
  a_flush_clears: assert property (flush |=> !overflow_error_flag && near_empty_flag)
    else $error("flush left data or overflow");
  a_flush_reads0: assert property (reg_rd && reg_addr == FBFC_ADDR_OCCUPANCY |=> !reg_rdata[7])
    else $error("flush bit read back as one");
  a_thresh_read: assert property (reg_rd && reg_addr == FBFC_ADDR_THRESHOLD |=> reg_rdata[7:6] == 2'h0)
    else $error("threshold upper bits not zero");
  a_wait_state: assert property (transceive_active && ms == FBFC_MODEM_IDLE |=> ms == FBFC_MODEM_WAIT)
    else $error("waiting code not shown");
  a_send_start: assert property (wr_frame && reg_wdata[7] && ms == FBFC_MODEM_WAIT && transceive_active
    |=> ms == FBFC_MODEM_SEND) else $error("trigger did not start sending");
  a_send_blocked: assert property (wr_frame && reg_wdata[7] && !transceive_active |=> ms != FBFC_MODEM_SEND)
    else $error("trigger acted outside send-then-receive");
  a_tx_hold: assert property (tx_valid && !tx_ready && !flush |=> tx_valid && $stable(tx_word))
    else $error("transmit word changed while stalled");
  // Main scenarios reached
  c_overflow: cover property (flush && overflow_error_flag);
  c_tx_stall: cover property (tx_valid && !tx_ready);
  c_sending: cover property (ms == FBFC_MODEM_SEND);
endmodule : fbfc_fifo_framing_chk

bind fbfc_fifo_framing fbfc_fifo_framing_chk u_chk (.*);

// ===== fbfc_serial_model.sv
// Partner: serial transmitter sink and receiver bit source facing the block
`timescale 1ns/1ps
module fbfc_serial_model
  import fbfc_pkg::*;
(
  // Clock
  input  wire logic          clock,
  // Transmit side
  input  wire logic          tx_valid,
  output logic               tx_ready,
  input  wire fbfc_tx_word_s tx_word,
  input  wire logic          stall,
  // Receive side
  output logic               rx_valid,
  input  wire logic          rx_ready,
  output fbfc_rx_bit_s       rx_bit
);
  fbfc_tx_word_s got[$];  // Words taken, in order
  int            hangs;   // Offers never taken
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_bit   = '0;
    hangs    = 0;
  end
  // Take whole bytes; stalling halves the accept rate to fill the skid
  always @(posedge clock) begin
    if (tx_valid && tx_ready) got.push_back(tx_word);
    tx_ready <= stall ? ~tx_ready : 1'b1;
  end
  // Offer one bit or frame end, held until the edge that takes it
  task automatic send(input logic b, input logic fe);
    int n;
    logic taken;
    @(posedge clock);
    rx_bit   <= '{b, fe};
    rx_valid <= 1'b1;
    // Ready is judged before the edge that could take the item
    taken = 1'b0;
    for (n = 0; n < 50 && !taken; n++) begin
      @(negedge clock) taken = rx_ready;
      @(posedge clock);
    end
    if (!taken) hangs++;
    rx_valid <= 1'b0;
    // Released line shows the inverse, so a stale bit cannot pass
    rx_bit   <= ~rx_bit;
  endtask : send
endmodule : fbfc_serial_model

// ===== fbfc_fifo_framing_test.sv
// Testbench: register-level tests of the FIFO and framing block
`timescale 1ns/1ps
module fbfc_fifo_framing_test;
  import fbfc_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic          clock, resetn, reg_wr, reg_rd, transceive_active, stall;
  logic [5:0]    reg_addr;
  logic [7:0]    reg_wdata, reg_rdata;
  logic          near_full_flag, near_empty_flag, overflow_error_flag;
  logic [2:0]    modem_state_indicator;
  logic          timer_halt_strobe, timer_launch_strobe, tx_valid, tx_ready, rx_valid, rx_ready;
  fbfc_tx_word_s tx_word;
  fbfc_rx_bit_s  rx_bit;
  int            fail_count, n_checks;
  fbfc_fifo_framing u_dut (.*);
  fbfc_serial_model u_ser (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // One write pulse; a gap cycle follows so strobes never merge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr
  // One read pulse; data looked at a full cycle later, masked bits only
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(posedge clock);
    #1;
    chk({4'h0, reg_rdata & m}, {4'h0, e & m});
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [10:0] pat;  // Serial bit patterns, first bit in bit 0
    resetn = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
    transceive_active = 1'b0; stall = 1'b0; fail_count = 0; n_checks = 0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    rd(FBFC_ADDR_OCCUPANCY, 8'h00);
    rd(FBFC_ADDR_THRESHOLD, 8'h08);
    rd(FBFC_ADDR_MISC_CTRL, 8'h10);
    rd(FBFC_ADDR_BIT_FRAME, 8'h00);
    rd(6'h20, 8'h00);
    wr(FBFC_ADDR_THRESHOLD, 8'hff);
    rd(FBFC_ADDR_THRESHOLD, 8'h3f);
    wr(FBFC_ADDR_BIT_FRAME, 8'hff);
    rd(FBFC_ADDR_BIT_FRAME, 8'h77);
    wr(FBFC_ADDR_MISC_CTRL, 8'hc0);
    rd(FBFC_ADDR_MISC_CTRL, 8'h10);
    $display("test registers done");
    // Fill to the brim with both warning edges passed, then overflow
    wr(FBFC_ADDR_THRESHOLD, 8'h04);
    for (int i = 1; i <= 64; i++) begin
      wr(FBFC_ADDR_DATA_PORT, 8'(i));
      chk({10'h0, near_full_flag, near_empty_flag}, {10'h0, i >= 60, i <= 4});
    end
    wr(FBFC_ADDR_DATA_PORT, 8'hee);
    chk({11'h0, overflow_error_flag}, 12'h001);
    rd(FBFC_ADDR_OCCUPANCY, 8'h40);
    for (int i = 1; i <= 64; i++) rd(FBFC_ADDR_DATA_PORT, 8'(i));
    rd(FBFC_ADDR_DATA_PORT, 8'h00);
    rd(FBFC_ADDR_OCCUPANCY, 8'h00);
    wr(FBFC_ADDR_DATA_PORT, 8'h5a);
    wr(FBFC_ADDR_OCCUPANCY, 8'h80);
    chk({11'h0, overflow_error_flag}, 12'h000);
    rd(FBFC_ADDR_OCCUPANCY, 8'h00);
    $display("test fill done");
    // Send three bytes under stall, last one partial
    wr(FBFC_ADDR_BIT_FRAME, 8'h03);
    for (int i = 1; i <= 3; i++) wr(FBFC_ADDR_DATA_PORT, 8'(i * 8'h11));
    @(posedge clock);
    stall             <= 1'b1;
    transceive_active <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk({9'h0, modem_state_indicator}, {9'h0, FBFC_MODEM_WAIT});
    wr(FBFC_ADDR_BIT_FRAME, 8'h83);
    for (int n = 0; n < 100 && u_ser.got.size() < 3; n++) @(posedge clock);
    if (u_ser.got.size() < 3) begin
      fail_count++;
      print_verdict();
    end
    chk(u_ser.got[0], 12'h110);
    chk(u_ser.got[1], 12'h220);
    chk(u_ser.got[2], 12'h33b);
    @(posedge clock);
    transceive_active <= 1'b0;
    wr(FBFC_ADDR_DATA_PORT, 8'h44);
    wr(FBFC_ADDR_BIT_FRAME, 8'h80);
    repeat (5) @(posedge clock);
    chk(12'(u_ser.got.size()), 12'h003);
    rd(FBFC_ADDR_OCCUPANCY, 8'h01);
    $display("test send done");
    // Receive one full and one partial byte, then an aligned frame
    wr(FBFC_ADDR_OCCUPANCY, 8'h80);
    wr(FBFC_ADDR_BIT_FRAME, 8'h00);
    pat = {3'b101, 8'ha5};
    for (int j = 0; j < 11; j++) u_ser.send(pat[j], 1'b0);
    u_ser.send(1'b0, 1'b1);
    rd(FBFC_ADDR_OCCUPANCY, 8'h02);
    rd(FBFC_ADDR_DATA_PORT, 8'ha5);
    rd(FBFC_ADDR_DATA_PORT, 8'h05, 8'h07);
    rd(FBFC_ADDR_MISC_CTRL, 8'h13);
    wr(FBFC_ADDR_OCCUPANCY, 8'h80);
    wr(FBFC_ADDR_BIT_FRAME, 8'h70);
    pat = {2'b00, 8'h3c, 1'b1};
    for (int j = 0; j < 9; j++) u_ser.send(pat[j], 1'b0);
    u_ser.send(1'b0, 1'b1);
    rd(FBFC_ADDR_OCCUPANCY, 8'h02);
    rd(FBFC_ADDR_DATA_PORT, 8'h80);
    rd(FBFC_ADDR_DATA_PORT, 8'h3c);
    rd(FBFC_ADDR_MISC_CTRL, 8'h10);
    chk(12'(u_ser.hangs), 12'h000);
    $display("test receive done");
    print_verdict();
  end
endmodule : fbfc_fifo_framing_test
